/* design/nca_core.sv */
`timescale 1ns/1ps
`include "nca_defines.svh"

module nca_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire nca_pkg::nca_instr_t instr_in,
  input wire logic [3:0] mem_rdata,
  input wire logic [8:0] rom_data,
  input wire logic [2:0] table_page,
  input wire logic table_upper_bit_select,
  input wire logic [1:0] logic_op_mode,
  output logic instr_ready_q,
  output logic [9:0] pc_q,
  output logic [`NCA_SP_W-1:0] sp_q,
  output logic [3:0] acc_q,
  output logic [3:0] reg_b_q,
  output logic carry_q,
  output logic [1:0] col_idx_q,
  output logic [3:0] row_idx_q,
  output logic skip_q,
  output nca_pkg::nca_mem_wr_t mem_wr_q
);
  import nca_pkg::*;

  nca_state_t state_q;
  nca_state_t state_d;
  logic [9:0] ret_stack [`NCA_STACK_DEPTH];
  logic last_ldi_q;
  logic last_ldx_q;

  logic instr_ready_d;
  logic [9:0] pc_d;
  logic [`NCA_SP_W-1:0] sp_d;
  logic [3:0] acc_d;
  logic [3:0] reg_b_d;
  logic carry_d;
  logic [1:0] col_idx_d;
  logic [3:0] row_idx_d;
  logic skip_d;
  logic last_ldi_d;
  logic last_ldx_d;
  nca_mem_wr_t mem_wr_d;
  logic push_en;

  // Decode
  wire [8:0] w = instr_in.word;
  wire take = instr_in.valid && instr_ready_q && (state_q == NCA_ST_RUN);
  wire is_ldi = (w[8:4] == `NCA_OP_LDI_ACC);
  wire is_ai = (w[8:4] == `NCA_OP_AI);
  wire is_tab = (w[8:3] == `NCA_OP_TAB_FETCH);
  wire is_ldx = (w[8:6] == `NCA_OP_LD_INDEX);
  wire is_ldm = (w[8:2] == `NCA_OP_LD_MEM);
  wire is_xch = (w[8:2] == `NCA_OP_SWAP);
  wire is_xch_dec = (w[8:2] == `NCA_OP_SWAP_DEC);
  wire is_xch_inc = (w[8:2] == `NCA_OP_SWAP_INC);
  wire is_swap = is_xch || is_xch_dec || is_xch_inc;
  wire is_addm = (w == `NCA_OP_ADD_MEM);
  wire is_addmc = (w == `NCA_OP_ADD_MEM_C);
  wire is_rot = (w == `NCA_OP_ROT_RIGHT);
  wire is_logic = (w == `NCA_OP_LOGIC);
  wire is_row_inc = (w == `NCA_OP_ROW_INC);
  wire is_row_dec = (w == `NCA_OP_ROW_DEC);

  // A run of the same immediate or index load executes once; the rest act as skipped words
  wire run_skip = (is_ldi && last_ldi_q) || (is_ldx && last_ldx_q);
  wire do_exec = take && !skip_q && !run_skip;

  // Arithmetic
  wire [4:0] sum_mem = {1'b0, acc_q} + {1'b0, mem_rdata};
  wire [4:0] sum_memc = sum_mem + {4'h0, carry_q};
  wire [4:0] sum_ai = {1'b0, acc_q} + {1'b0, w[3:0]};
  wire [3:0] row_inc = row_idx_q + 4'h1;
  wire [3:0] row_dec = row_idx_q - 4'h1;
  wire [1:0] col_xor = col_idx_q ^ w[1:0];
  wire [3:0] lop_xor = acc_q ^ reg_b_q;
  wire [3:0] lop_or = acc_q | reg_b_q;
  wire [3:0] lop_and = acc_q & reg_b_q;
  // Unassigned mode code falls back to XOR so the result is always defined
  wire [3:0] lop_res = (logic_op_mode == `NCA_LOP_OR) ? lop_or :
                       (logic_op_mode == `NCA_LOP_AND) ? lop_and : lop_xor;
  wire [`NCA_SP_W-1:0] sp_dec = sp_q - `NCA_SP_W'(1);

  always_comb begin
    state_d = state_q;
    instr_ready_d = instr_ready_q;
    pc_d = pc_q;
    sp_d = sp_q;
    acc_d = acc_q;
    reg_b_d = reg_b_q;
    carry_d = carry_q;
    col_idx_d = col_idx_q;
    row_idx_d = row_idx_q;
    skip_d = skip_q;
    last_ldi_d = last_ldi_q;
    last_ldx_d = last_ldx_q;
    mem_wr_d = '0;
    push_en = 1'b0;
    case (state_q)
      NCA_ST_RUN: begin
        if (take) begin
          pc_d = pc_q + 10'h001;
          skip_d = 1'b0;
          last_ldi_d = is_ldi;
          last_ldx_d = is_ldx;
        end
        if (do_exec) begin
          if (is_ldi) begin
            acc_d = w[3:0];
          end else if (is_ai) begin
            acc_d = sum_ai[3:0];
          end else if (is_addm) begin
            acc_d = sum_mem[3:0];
          end else if (is_addmc) begin
            acc_d = sum_memc[3:0];
            carry_d = sum_memc[4];
          end else if (is_rot) begin
            acc_d = {carry_q, acc_q[3:1]};
            carry_d = acc_q[0];
          end else if (is_logic) begin
            acc_d = lop_res;
          end else if (is_ldx) begin
            col_idx_d = w[5:4];
            row_idx_d = w[3:0];
          end else if (is_row_inc) begin
            row_idx_d = row_inc;
            skip_d = (row_inc == `NCA_Y_WRAP_INC);
          end else if (is_row_dec) begin
            row_idx_d = row_dec;
            skip_d = (row_dec == `NCA_Y_WRAP_DEC);
          end else if (is_ldm) begin
            acc_d = mem_rdata;
            col_idx_d = col_xor;
          end else if (is_swap) begin
            acc_d = mem_rdata;
            mem_wr_d.we = 1'b1;
            mem_wr_d.addr = {col_idx_q, row_idx_q};
            mem_wr_d.wdata = acc_q;
            col_idx_d = col_xor;
            if (is_xch_dec) begin
              row_idx_d = row_dec;
              skip_d = (row_dec == `NCA_Y_WRAP_DEC);
            end else if (is_xch_inc) begin
              row_idx_d = row_inc;
              skip_d = (row_inc == `NCA_Y_WRAP_INC);
            end
          end else if (is_tab) begin
            push_en = 1'b1;
            sp_d = sp_q + `NCA_SP_W'(1);
            pc_d = {w[2:0], table_page, acc_q};
            instr_ready_d = 1'b0;
            state_d = NCA_ST_TAB_ROM;
          end
        end
      end
      NCA_ST_TAB_ROM: begin
        // ROM answers combinationally for the address now on pc_q
        reg_b_d = rom_data[7:4];
        acc_d = rom_data[3:0];
        if (table_upper_bit_select) begin
          carry_d = rom_data[8];
        end
        sp_d = sp_dec;
        state_d = NCA_ST_TAB_RET;
      end
      NCA_ST_TAB_RET: begin
        pc_d = ret_stack[sp_q];
        instr_ready_d = 1'b1;
        state_d = NCA_ST_RUN;
      end
      default: begin
        state_d = NCA_ST_RUN;
        instr_ready_d = 1'b1;
      end
    endcase
  end

  // The stack holds return addresses only; an overflow wraps silently,
  // so nesting deeper than the stack corrupts the oldest entry.
  always_ff @(posedge clk_sys) begin
    if (ce && push_en) begin
      ret_stack[sp_q] <= pc_q + 10'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= NCA_ST_RUN;
      instr_ready_q <= 1'b1;
      pc_q <= `NCA_RST_PC;
      sp_q <= `NCA_RST_SP;
      skip_q <= 1'b0;
      last_ldi_q <= 1'b0;
      last_ldx_q <= 1'b0;
      mem_wr_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      instr_ready_q <= instr_ready_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      skip_q <= skip_d;
      last_ldi_q <= last_ldi_d;
      last_ldx_q <= last_ldx_d;
      mem_wr_q <= mem_wr_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_q <= `NCA_RST_NIB;
      reg_b_q <= `NCA_RST_NIB;
      carry_q <= 1'b0;
      col_idx_q <= 2'h0;
      row_idx_q <= `NCA_RST_NIB;
    end else if (ce) begin
      acc_q <= acc_d;
      reg_b_q <= reg_b_d;
      carry_q <= carry_d;
      col_idx_q <= col_idx_d;
      row_idx_q <= row_idx_d;
    end
  end

endmodule

/* shared/nca_defines.svh */
`ifndef NCA_DEFINES_SVH
`define NCA_DEFINES_SVH

// Opcode patterns, compared against the top bits of the 9-bit word
`define NCA_OP_LDI_ACC 5'h0B
`define NCA_OP_AI 5'h0A
`define NCA_OP_TAB_FETCH 6'h12
`define NCA_OP_LD_INDEX 3'h3
`define NCA_OP_LD_MEM 7'h19
`define NCA_OP_SWAP 7'h18
`define NCA_OP_SWAP_DEC 7'h1B
`define NCA_OP_SWAP_INC 7'h1A
`define NCA_OP_ADD_MEM 9'h00A
`define NCA_OP_ADD_MEM_C 9'h00B
`define NCA_OP_ROT_RIGHT 9'h01D
`define NCA_OP_LOGIC 9'h041
`define NCA_OP_ROW_INC 9'h013
`define NCA_OP_ROW_DEC 9'h017

// Logic operation selector codes
`define NCA_LOP_XOR 2'h0
`define NCA_LOP_OR 2'h1
`define NCA_LOP_AND 2'h2

// Row index skip points
`define NCA_Y_WRAP_INC 4'h0
`define NCA_Y_WRAP_DEC 4'hF

// Return stack geometry
`define NCA_STACK_DEPTH 4
`define NCA_SP_W 2

// Reset values
`define NCA_RST_NIB 4'h0
`define NCA_RST_PC 10'h000
`define NCA_RST_SP 2'h0

`endif

/* shared/nca_pkg.sv */
package nca_pkg;

  typedef enum logic [1:0] {
    NCA_ST_RUN,
    NCA_ST_TAB_ROM,
    NCA_ST_TAB_RET
  } nca_state_t;

  typedef struct packed {
    logic valid;
    logic [8:0] word;
  } nca_instr_t;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [3:0] wdata;
  } nca_mem_wr_t;

endpackage

/* tb/nca_core_sva.sv */
`timescale 1ns/1ps
module nca_core_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic table_upper_bit_select,
  input wire nca_pkg::nca_instr_t instr_in,
  input wire logic [3:0] mem_rdata,
  input wire logic [3:0] acc_q,
  input wire logic [3:0] reg_b_q,
  input wire logic [3:0] row_idx_q,
  input wire logic [8:0] rom_data,
  input wire logic [2:0] table_page,
  input wire logic [1:0] logic_op_mode,
  input wire logic [1:0] sp_q,
  input wire logic [1:0] col_idx_q,
  input wire logic instr_ready_q,
  input wire logic carry_q,
  input wire logic skip_q,
  input wire logic [9:0] pc_q,
  input wire nca_pkg::nca_mem_wr_t mem_wr_q
);
  import nca_pkg::*;
  logic ldi_run_q;
  wire [8:0] w = instr_in.word;
  wire tk = ce && instr_in.valid && instr_ready_q;
  wire ex = tk && !skip_q;
  wire ldi = w[8:4] == 5'h0B;
  wire tab = ex && w[8:3] == 6'h12;
  wire [4:0] sum = acc_q + mem_rdata + (w[0] & carry_q);
  wire [3:0] lop = logic_op_mode == 2'h1 ? acc_q | reg_b_q :
    logic_op_mode == 2'h2 ? acc_q & reg_b_q : acc_q ^ reg_b_q;
  // A skipped repeat still extends the run
  always_ff @(posedge clk_sys) begin
    if (rst) ldi_run_q <= 1'b0;
    else if (tk) ldi_run_q <= ldi;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  imm_load_a: assert property (ex && ldi && !ldi_run_q |=> acc_q == $past(w[3:0]))
    else $error("bad load");
  imm_run_a: assert property (tk && ldi && ldi_run_q |=> $stable(acc_q))
    else $error("repeat acted");
  tab_call_a: assert property (tab |=> !instr_ready_q &&
    sp_q == $past(sp_q) + 2'h1 && pc_q == {$past(w[2:0]), $past(table_page), $past(acc_q)})
    else $error("bad call");
  tab_data_a: assert property (tab |=> ##1
    {reg_b_q, acc_q} == $past(rom_data[7:0]) &&
    carry_q == ($past(table_upper_bit_select) ? $past(rom_data[8]) : $past(carry_q, 2)))
    else $error("bad fetch");
  tab_ret_a: assert property (tab |-> ##3 instr_ready_q &&
    sp_q == $past(sp_q, 3) && pc_q == $past(pc_q, 3) + 10'h1) else $error("bad return");
  add_mem_a: assert property (ex && w[8:1] == 8'h05 |=>
    acc_q == $past(sum[3:0]) && (!$past(w[0]) || carry_q == $past(sum[4])))
    else $error("bad add");
  logic_a: assert property (ex && w == 9'h041 |=> acc_q == $past(lop))
    else $error("bad logic");
  mem_swap_a: assert property (ex && w[8:4] == 5'h06 |=>
    acc_q == $past(mem_rdata) && col_idx_q == ($past(col_idx_q) ^ $past(w[1:0])) &&
    mem_wr_q.we == ($past(w[3:2]) != 2'h1)) else $error("bad swap");
  add_imm_a: assert property (ex && w[8:4] == 5'h0A |=>
    acc_q == $past(acc_q) + $past(w[3:0])) else $error("bad immediate add");
  rot_carry_a: assert property (ex && w == 9'h01D |=>
    acc_q == {$past(carry_q), $past(acc_q[3:1])} && carry_q == $past(acc_q[0]))
    else $error("bad rotate");
  row_step_a: assert property (ex && (w == 9'h013 || w == 9'h017) |=>
    row_idx_q == $past(row_idx_q) + ($past(w[2]) ? 4'hF : 4'h1) &&
    skip_q == (row_idx_q == ($past(w[2]) ? 4'hF : 4'h0))) else $error("bad row step");
  cover property (tab);
  cover property (tk && ldi && ldi_run_q);
  cover property (ex && w == 9'h013 ##1 skip_q);
endmodule
bind nca_core nca_core_sva chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .ce(ce),
  .table_upper_bit_select(table_upper_bit_select),
  .instr_in(instr_in),
  .mem_rdata(mem_rdata),
  .acc_q(acc_q),
  .reg_b_q(reg_b_q),
  .row_idx_q(row_idx_q),
  .rom_data(rom_data),
  .table_page(table_page),
  .logic_op_mode(logic_op_mode),
  .sp_q(sp_q),
  .col_idx_q(col_idx_q),
  .instr_ready_q(instr_ready_q),
  .carry_q(carry_q),
  .skip_q(skip_q),
  .pc_q(pc_q),
  .mem_wr_q(mem_wr_q)
);

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import nca_pkg::*;
  logic clk_sys = 0, rst = 1, ce = 1, tus = 0, rdy, cf, skp, c = 0;
  logic [3:0] mrd = 0, a, n, acc, b, row;
  logic [8:0] rom = 0;
  logic [2:0] tp = 0;
  logic [1:0] lom = 0, sp, col;
  logic [9:0] pc, pb;
  logic [4:0] e;
  nca_instr_t ins = '0;
  nca_mem_wr_t mw;
  int seed = 39, miscompares = 0, checked = 0, i;
  always #5 clk_sys = ~clk_sys;
  nca_core dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .instr_in(ins), .mem_rdata(mrd),
    .rom_data(rom), .table_page(tp), .table_upper_bit_select(tus), .logic_op_mode(lom),
    .instr_ready_q(rdy), .pc_q(pc), .sp_q(sp), .acc_q(acc), .reg_b_q(b), .carry_q(cf),
    .col_idx_q(col), .row_idx_q(row), .skip_q(skp), .mem_wr_q(mw));
  task automatic test_done;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      miscompares++;
      $display("MISMATCH %0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Offers one word for a single edge, then waits out a table fetch; idle
  // edges in between are harmless since only taken words move the run state.
  task automatic op(input logic [8:0] w);
    @(posedge clk_sys);
    ins <= {1'b1, w};
    @(posedge clk_sys);
    ins.valid <= 1'b0;
    @(negedge clk_sys);
    for (int k = 0; k < 4 && rdy !== 1'b1; k++) begin
      @(negedge clk_sys);
    end
    if (rdy !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask
  function automatic logic [3:0] lg(input logic [1:0] m, input logic [3:0] x, y);
    return m == 2'h1 ? x | y : m == 2'h2 ? x & y : x ^ y;
  endfunction
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 32; i++) begin
      {a, n} = 8'($random(seed));
      // Force row wrap corners: swap steps when i[3] is set, single steps otherwise
      if (i[1]) n = i[3] ? {4{~i[2]}} : {4{i[4]}};
      @(posedge clk_sys);
      {mrd, rom, tp, tus, lom} <= 19'($random(seed));
      op({5'h0B, a});
      op({5'h0B, n});
      chk(acc, a);
      op({8'h05, i[0]});
      e = a + mrd + (i[0] & c);
      if (i[0]) c = e[4];
      chk({cf, acc}, {c, e[3:0]});
      e[3:0] = e[3:0] + n;
      op({5'h0A, n});
      op(9'h01D);
      chk({cf, acc}, {e[0], c, e[3:1]});
      pb = pc;
      op({6'h12, n[2:0]});
      c = tus ? rom[8] : e[0];
      chk({sp, pc - pb}, {2'h0, 10'h001});
      chk({cf, b, acc}, {c, rom[7:0]});
      // A word offered while the clock enable is low must leave no trace
      pb = pc;
      @(posedge clk_sys);
      ce <= 1'b0;
      op(9'h041);
      @(posedge clk_sys);
      ce <= 1'b1;
      op(9'h041);
      e[3:0] = lg(lom, rom[3:0], rom[7:4]);
      chk({acc, pc - pb}, {e[3:0], 10'h001});
      op({3'h3, a[1:0], n});
      op({3'h3, ~a[1:0], ~n});
      chk({col, row}, {a[1:0], n});
      op({5'h06, i[3:2], a[3:2]});
      if (i[3:2] != 2'h1) chk(mw, {1'b1, a[1:0], n, e[3:0]});
      n = n + {{3{i[3] & i[2]}}, i[3]};
      chk({skp, col, row, acc}, {i[3] && n == {4{i[2]}}, a[1:0] ^ a[3:2], n, mrd});
      op(9'h000);
      op(i[4] ? 9'h013 : 9'h017);
      n = n + {{3{~i[4]}}, 1'b1};
      e[4] = n == {4{~i[4]}};
      chk({skp, row}, {e[4], n});
      op({5'h0A, a});
      chk(acc, e[4] ? mrd : 4'(mrd + a));
    end
    test_done();
  end
endmodule
